// file: hw/dssp_top.sv
// Debug and test access port: TAP, boundary chain, processor chains, debug channel.
`timescale 1ns/1ps
`include "dssp_params.svh"
`default_nettype none
module dssp_top #(
	parameter int NPINS = `DSSP_NPINS,
	parameter logic [31:0] CHIP_ID = `DSSP_CHIP_ID,
	parameter logic [31:0] PROC_ID = `DSSP_PROC_ID
) (
	// System clock, reset and enable.
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic clk_en,
	// Mode pin and access control.
	input wire logic scan_mode_select,
	input wire logic ice_access_block,
	output logic ice_mode,
	output logic [31:0] chip_id,
	// Test port.
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	// Pads.
	input wire logic [NPINS-1:0] func_out,
	input wire logic [NPINS-1:0] func_oe,
	input wire logic [NPINS-1:0] pad_in,
	output logic [NPINS-1:0] pad_out,
	output logic [NPINS-1:0] pad_oe,
	// Processor debug.
	output logic insn_valid,
	output logic [31:0] insn_word,
	output logic halt_req,
	input wire logic core_export_valid,
	input wire logic [31:0] core_export_word,
	// Debug channel.
	input wire logic core_tx_valid,
	input wire logic [31:0] core_tx_word,
	input wire logic core_rx_ack,
	output logic [31:0] dcc_rx_word,
	output logic debug_chan_rx_event,
	output logic debug_chan_tx_event
);
	localparam int BL = `DSSP_BSC_LEN;
	initial begin
		if (NPINS * 3 != BL) $error("Pin count does not fill the boundary chain.");
	end

	typedef struct packed {
		logic sel1, sel2, ice, blk, halt1, halt2, halt, ext1, ext2;
		logic [NPINS-1:0] bo1, bo2, bc1, bc2, pout, poe;
		logic inj1, inj2, inj3, rx1, rx2, rx3, ack1, ack2, ack3;
		logic ivalid, rx_full, tx_free, tx_tog, exp_tog;
		logic [31:0] iword, rx_word, tx_word, exp_word, id;
	} dssp_m_t;

	typedef struct packed {
		logic r1, r2, ice1, ice2, bk1, bk2;
		logic [NPINS-1:0] pi1, pi2, uo, uc;
		dssp_pkg::dssp_tap_t st;
		logic [3:0] ir, irs, sel;
		logic [BL-1:0] sh;
		logic halt, inj_tog, rx_tog, ack_tog, tdo, tdo_oe;
		logic tx1, tx2, tx3, ex1, ex2, ex3, tx_pend, rf1, rf2;
		logic [31:0] inj_w, rx_w, tx_w, exp_w;
	} dssp_t_t;

	dssp_m_t m_reg, m_next;
	dssp_t_t t_reg, t_next;

	function automatic dssp_pkg::dssp_tap_t tap_step(input dssp_pkg::dssp_tap_t s,
			input logic m);
		case (s)
			dssp_pkg::ST_TLR: tap_step = m ? dssp_pkg::ST_TLR : dssp_pkg::ST_RTI;
			dssp_pkg::ST_RTI: tap_step = m ? dssp_pkg::ST_SELDR : dssp_pkg::ST_RTI;
			dssp_pkg::ST_SELDR: tap_step = m ? dssp_pkg::ST_SELIR : dssp_pkg::ST_CAPDR;
			dssp_pkg::ST_CAPDR: tap_step = m ? dssp_pkg::ST_EX1DR : dssp_pkg::ST_SHDR;
			dssp_pkg::ST_SHDR: tap_step = m ? dssp_pkg::ST_EX1DR : dssp_pkg::ST_SHDR;
			dssp_pkg::ST_EX1DR: tap_step = m ? dssp_pkg::ST_UPDR : dssp_pkg::ST_PDR;
			dssp_pkg::ST_PDR: tap_step = m ? dssp_pkg::ST_EX2DR : dssp_pkg::ST_PDR;
			dssp_pkg::ST_EX2DR: tap_step = m ? dssp_pkg::ST_UPDR : dssp_pkg::ST_SHDR;
			dssp_pkg::ST_UPDR: tap_step = m ? dssp_pkg::ST_SELDR : dssp_pkg::ST_RTI;
			dssp_pkg::ST_SELIR: tap_step = m ? dssp_pkg::ST_TLR : dssp_pkg::ST_CAPIR;
			dssp_pkg::ST_CAPIR: tap_step = m ? dssp_pkg::ST_EX1IR : dssp_pkg::ST_SHIR;
			dssp_pkg::ST_SHIR: tap_step = m ? dssp_pkg::ST_EX1IR : dssp_pkg::ST_SHIR;
			dssp_pkg::ST_EX1IR: tap_step = m ? dssp_pkg::ST_UPIR : dssp_pkg::ST_PIR;
			dssp_pkg::ST_PIR: tap_step = m ? dssp_pkg::ST_EX2IR : dssp_pkg::ST_PIR;
			dssp_pkg::ST_EX2IR: tap_step = m ? dssp_pkg::ST_UPIR : dssp_pkg::ST_SHIR;
			dssp_pkg::ST_UPIR: tap_step = m ? dssp_pkg::ST_SELDR : dssp_pkg::ST_RTI;
			default: tap_step = dssp_pkg::ST_TLR;
		endcase
	endfunction : tap_step

	// Picks the data register for an instruction in the current mode.
	function automatic dssp_pkg::dssp_dr_t dr_pick(input logic [3:0] op, input logic ice,
			input logic blk);
		dr_pick = dssp_pkg::DR_BYPASS;
		if (!ice) begin
			if (op == `DSSP_OP_EXTEST || op == `DSSP_OP_SAMPLE) dr_pick = dssp_pkg::DR_BSC;
		end else if (!blk) begin
			case (op)
				`DSSP_OP_IDCODE: dr_pick = dssp_pkg::DR_ID;
				`DSSP_OP_SCAN_N: dr_pick = dssp_pkg::DR_SCANN;
				`DSSP_OP_INTEST: dr_pick = dssp_pkg::DR_CHAIN;
				default: dr_pick = dssp_pkg::DR_BYPASS;
			endcase
		end
	endfunction : dr_pick

	// Length of the selected data register.
	function automatic int dr_len(input dssp_pkg::dssp_dr_t d, input logic [3:0] sel);
		case (d)
			dssp_pkg::DR_ID: dr_len = 32;
			dssp_pkg::DR_BSC: dr_len = BL;
			dssp_pkg::DR_SCANN: dr_len = 4;
			dssp_pkg::DR_CHAIN: dr_len = (sel == 4'h0) ? `DSSP_CHAIN0_LEN :
				(sel == 4'h1) ? `DSSP_CHAIN1_LEN : (sel == 4'h2) ? `DSSP_CHAIN2_LEN : 1;
			default: dr_len = 1;
		endcase
	endfunction : dr_len

	// Test clock domain: TAP, shift paths and update registers.
	always_comb begin
		dssp_pkg::dssp_dr_t d;
		int len;
		d = dr_pick(t_reg.ir, t_reg.ice2, t_reg.bk2);
		len = dr_len(d, t_reg.sel);
		t_next = t_reg;
		t_next.r1 = rst_b;
		t_next.r2 = t_reg.r1;
		t_next.ice1 = m_reg.ice;
		t_next.ice2 = t_reg.ice1;
		t_next.bk1 = m_reg.blk;
		t_next.bk2 = t_reg.bk1;
		t_next.pi1 = pad_in;
		t_next.pi2 = t_reg.pi1;
		t_next.tx1 = m_reg.tx_tog;
		t_next.tx2 = t_reg.tx1;
		t_next.tx3 = t_reg.tx2;
		t_next.ex1 = m_reg.exp_tog;
		t_next.ex2 = t_reg.ex1;
		t_next.ex3 = t_reg.ex2;
		t_next.rf1 = m_reg.rx_full;
		t_next.rf2 = t_reg.rf1;
		if (t_reg.tx2 != t_reg.tx3) begin
			t_next.tx_w = m_reg.tx_word;
			t_next.tx_pend = 1'b1;
		end
		if (t_reg.ex2 != t_reg.ex3) t_next.exp_w = m_reg.exp_word;
		t_next.st = tap_step(t_reg.st, tms);
		case (t_reg.st)
			dssp_pkg::ST_TLR: begin
				t_next.ir = `DSSP_OP_IDCODE;
				t_next.halt = 1'b0;
			end
			dssp_pkg::ST_CAPIR: t_next.irs = `DSSP_IR_CAPTURE;
			dssp_pkg::ST_SHIR: t_next.irs = {tdi, t_reg.irs[3:1]};
			dssp_pkg::ST_UPIR: begin
				t_next.ir = t_reg.irs;
				if (t_reg.ice2 && !t_reg.bk2) begin
					if (t_reg.irs == `DSSP_OP_HALT) t_next.halt = 1'b1;
					if (t_reg.irs == `DSSP_OP_RESTART) t_next.halt = 1'b0;
				end
			end
			dssp_pkg::ST_CAPDR: begin
				t_next.sh = '0;
				case (d)
					dssp_pkg::DR_ID: t_next.sh[31:0] = PROC_ID;
					dssp_pkg::DR_SCANN: t_next.sh[3:0] = `DSSP_SCAN_N_CAPTURE;
					dssp_pkg::DR_BSC: begin
						for (int k = 0; k < NPINS; k++) begin
							t_next.sh[3*k+2] = t_reg.pi2[k];
							t_next.sh[3*k+1] = t_reg.uo[k];
							t_next.sh[3*k] = t_reg.uc[k];
						end
					end
					dssp_pkg::DR_CHAIN: begin
						if (t_reg.sel == 4'h0) begin
							t_next.sh[7:0] = {5'h00, t_reg.rf2, t_reg.tx_pend, t_reg.halt};
						end else if (t_reg.sel == 4'h1) begin
							t_next.sh[31:0] = t_reg.exp_w;
						end else if (t_reg.sel == 4'h2) begin
							t_next.sh[32:0] = {t_reg.tx_pend, t_reg.tx_w};
							if (t_reg.tx_pend) begin
								t_next.tx_pend = 1'b0;
								t_next.ack_tog = ~t_reg.ack_tog;
							end
						end
					end
					default: t_next.sh[0] = 1'b0;
				endcase
			end
			dssp_pkg::ST_SHDR: begin
				t_next.sh = t_reg.sh >> 1;
				t_next.sh[len-1] = tdi;
			end
			dssp_pkg::ST_UPDR: begin
				if (d == dssp_pkg::DR_BSC) begin
					for (int k = 0; k < NPINS; k++) begin
						t_next.uo[k] = t_reg.sh[3*k+1];
						t_next.uc[k] = t_reg.sh[3*k];
					end
				end
				if (d == dssp_pkg::DR_SCANN) t_next.sel = t_reg.sh[3:0];
				if (d == dssp_pkg::DR_CHAIN && t_reg.sel == 4'h1 && t_reg.halt) begin
					t_next.inj_w = t_reg.sh[31:0];
					t_next.inj_tog = ~t_reg.inj_tog;
				end
				if (d == dssp_pkg::DR_CHAIN && t_reg.sel == 4'h2 && t_reg.sh[32]) begin
					t_next.rx_w = t_reg.sh[31:0];
					t_next.rx_tog = ~t_reg.rx_tog;
				end
			end
			default: t_next.sh = t_reg.sh;
		endcase
		t_next.tdo_oe = (t_next.st == dssp_pkg::ST_SHDR) || (t_next.st == dssp_pkg::ST_SHIR);
		t_next.tdo = (t_next.st == dssp_pkg::ST_SHIR) ? t_next.irs[0] : t_next.sh[0];
		if (!t_reg.r2) begin
			t_next.st = dssp_pkg::ST_TLR;
			t_next.ir = `DSSP_OP_IDCODE;
			t_next.irs = '0;
			t_next.sel = '0;
			t_next.sh = '0;
			t_next.uo = '0;
			t_next.uc = '0;
			t_next.halt = 1'b0;
			t_next.tx_pend = 1'b0;
			t_next.tdo = 1'b0;
			t_next.tdo_oe = 1'b0;
			t_next.inj_w = '0;
			t_next.rx_w = '0;
			t_next.tx_w = '0;
			t_next.exp_w = '0;
			t_next.inj_tog = 1'b0;
			t_next.rx_tog = 1'b0;
			t_next.ack_tog = 1'b0;
		end
	end

	always_ff @(posedge tck) begin
		t_reg <= t_next;
	end

	// System clock domain: mode latch, pad drive, debug channel and injection.
	always_comb begin
		m_next = m_reg;
		m_next.sel1 = scan_mode_select;
		m_next.sel2 = m_reg.sel1;
		m_next.blk = ice_access_block;
		m_next.halt1 = t_reg.halt;
		m_next.halt2 = m_reg.halt1;
		m_next.halt = m_reg.halt2 && m_reg.ice && !m_reg.blk;
		m_next.ext1 = !m_reg.ice && (t_reg.ir == `DSSP_OP_EXTEST);
		m_next.ext2 = m_reg.ext1;
		m_next.bo1 = t_reg.uo;
		m_next.bo2 = m_reg.bo1;
		m_next.bc1 = t_reg.uc;
		m_next.bc2 = m_reg.bc1;
		m_next.pout = m_reg.ext2 ? m_reg.bo2 : func_out;
		m_next.poe = m_reg.ext2 ? m_reg.bc2 : func_oe;
		m_next.inj1 = t_reg.inj_tog;
		m_next.inj2 = m_reg.inj1;
		m_next.inj3 = m_reg.inj2;
		m_next.rx1 = t_reg.rx_tog;
		m_next.rx2 = m_reg.rx1;
		m_next.rx3 = m_reg.rx2;
		m_next.ack1 = t_reg.ack_tog;
		m_next.ack2 = m_reg.ack1;
		m_next.ack3 = m_reg.ack2;
		m_next.ivalid = (m_reg.inj2 != m_reg.inj3) && m_reg.ice && !m_reg.blk;
		if (m_reg.inj2 != m_reg.inj3) m_next.iword = t_reg.inj_w;
		if (core_rx_ack) m_next.rx_full = 1'b0;
		if (m_reg.rx2 != m_reg.rx3) begin
			m_next.rx_full = 1'b1;
			m_next.rx_word = t_reg.rx_w;
		end
		if (m_reg.ack2 != m_reg.ack3) m_next.tx_free = 1'b1;
		if (core_tx_valid && m_reg.tx_free) begin
			m_next.tx_free = 1'b0;
			m_next.tx_word = core_tx_word;
			m_next.tx_tog = ~m_reg.tx_tog;
		end
		if (core_export_valid) begin
			m_next.exp_word = core_export_word;
			m_next.exp_tog = ~m_reg.exp_tog;
		end
		m_next.id = CHIP_ID;
		if (!clk_en) m_next = m_reg;
		if (!rst_b) begin
			m_next = '0;
			m_next.sel1 = scan_mode_select;
			m_next.sel2 = m_reg.sel1;
			m_next.ice = !m_reg.sel2;
			m_next.tx_free = 1'b1;
			m_next.id = CHIP_ID;
		end
	end

	always_ff @(posedge mclk) begin
		m_reg <= m_next;
	end

	assign ice_mode = m_reg.ice;
	assign chip_id = m_reg.id;
	assign tdo = t_reg.tdo;
	assign tdo_oe = t_reg.tdo_oe;
	assign pad_out = m_reg.pout;
	assign pad_oe = m_reg.poe;
	assign insn_valid = m_reg.ivalid;
	assign insn_word = m_reg.iword;
	assign halt_req = m_reg.halt;
	assign dcc_rx_word = m_reg.rx_word;
	assign debug_chan_rx_event = m_reg.rx_full;
	assign debug_chan_tx_event = m_reg.tx_free;
endmodule : dssp_top
`default_nettype wire

// file: pkg/dssp_params.svh
// Constants of the debug scan select port.
`ifndef DSSP_PARAMS_SVH
`define DSSP_PARAMS_SVH
`define DSSP_NPINS 63
`define DSSP_BSC_LEN 189
`define DSSP_IR_W 4
`define DSSP_IR_CAPTURE 4'h1
`define DSSP_OP_EXTEST 4'h0
`define DSSP_OP_SAMPLE 4'h1
`define DSSP_OP_SCAN_N 4'h2
`define DSSP_OP_RESTART 4'h4
`define DSSP_OP_HALT 4'h8
`define DSSP_OP_INTEST 4'hc
`define DSSP_OP_IDCODE 4'he
`define DSSP_OP_BYPASS 4'hf
`define DSSP_CHAIN0_LEN 8
`define DSSP_CHAIN1_LEN 33
`define DSSP_CHAIN2_LEN 33
`define DSSP_SCAN_N_CAPTURE 4'h8
`define DSSP_CHIP_ID 32'h0a5a_0001
`define DSSP_PROC_ID 32'h1f0f_0f0f
`endif

// file: pkg/dssp_pkg.sv
// Types of the debug scan select port.
`default_nettype none
package dssp_pkg;
	typedef enum logic [15:0] {
		ST_TLR = 16'h0001, ST_RTI = 16'h0002, ST_SELDR = 16'h0004, ST_CAPDR = 16'h0008,
		ST_SHDR = 16'h0010, ST_EX1DR = 16'h0020, ST_PDR = 16'h0040, ST_EX2DR = 16'h0080,
		ST_UPDR = 16'h0100, ST_SELIR = 16'h0200, ST_CAPIR = 16'h0400, ST_SHIR = 16'h0800,
		ST_EX1IR = 16'h1000, ST_PIR = 16'h2000, ST_EX2IR = 16'h4000, ST_UPIR = 16'h8000
	} dssp_tap_t;
	typedef enum logic [2:0] {
		DR_BYPASS = 3'h0, DR_ID = 3'h1, DR_BSC = 3'h2, DR_SCANN = 3'h3, DR_CHAIN = 3'h4
	} dssp_dr_t;
endpackage : dssp_pkg
`default_nettype wire

// file: tb/dssp_top_sva.sv
// Checker of the debug scan select port.
`timescale 1ns/1ps
`default_nettype none
module dssp_top_sva #(
	parameter int NPINS = 63,
	parameter logic [31:0] CHIP_ID = 32'h0
) (
	// Watched ports.
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic ice_access_block,
	input wire logic ice_mode,
	input wire logic [31:0] chip_id,
	input wire logic [NPINS-1:0] func_out,
	input wire logic [NPINS-1:0] func_oe,
	input wire logic [NPINS-1:0] pad_out,
	input wire logic [NPINS-1:0] pad_oe,
	input wire logic insn_valid,
	input wire logic halt_req,
	input wire logic core_tx_valid,
	input wire logic core_rx_ack,
	input wire logic debug_chan_rx_event,
	input wire logic debug_chan_tx_event
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	a_chip_id_fixed: assert property (chip_id == CHIP_ID)
		else $error("chip id differs");
	a_mode_kept: assert property ($stable(ice_mode))
		else $error("mode changed outside reset");
	a_scan_no_halt: assert property (!ice_mode |-> !halt_req && !insn_valid)
		else $error("emulation activity in scan mode");
	a_pad_follow: assert property (ice_mode && clk_en |=>
		pad_out == $past(func_out) && pad_oe == $past(func_oe))
		else $error("pads do not follow core");
	a_insn_pulse: assert property (insn_valid |=> !insn_valid)
		else $error("insert strobe too long");
	a_tx_taken: assert property (core_tx_valid && debug_chan_tx_event && clk_en
		|-> ##[1:2] !debug_chan_tx_event)
		else $error("transmit slot stays free");
	a_rx_cleared: assert property (core_rx_ack && debug_chan_rx_event |=>
		!debug_chan_rx_event)
		else $error("receive event not cleared");
	a_block_halt: assert property (ice_access_block && !halt_req |=> !halt_req)
		else $error("halt while blocked");
endmodule : dssp_top_sva
bind dssp_top dssp_top_sva #(.NPINS(NPINS), .CHIP_ID(CHIP_ID)) u_sva (.mclk(mclk),
	.rst_b(rst_b), .clk_en(clk_en), .ice_access_block(ice_access_block),
	.ice_mode(ice_mode), .chip_id(chip_id), .func_out(func_out), .func_oe(func_oe),
	.pad_out(pad_out), .pad_oe(pad_oe), .insn_valid(insn_valid), .halt_req(halt_req),
	.core_tx_valid(core_tx_valid), .core_rx_ack(core_rx_ack),
	.debug_chan_rx_event(debug_chan_rx_event), .debug_chan_tx_event(debug_chan_tx_event));
`default_nettype wire

// file: tb/dssp_dbg_host.sv
// Model of the external debugger driving the test port.
`timescale 1ns/1ps
`default_nettype none
module dssp_dbg_host (
	// Test port.
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo,
	input wire logic tdo_oe
);
	logic [199:0] dout;
	logic [3:0] irc;
	// The board ties the factory test pin low, so it never reaches the block.
	initial begin
		tck = 1'b0;
		tms = 1'b0;
		tdi = 1'b0;
	end
	// One test clock period; the clock stands low outside it.
	task tick(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#37;
		o = tdo_oe ? tdo : 1'bz;
		tck = 1'b1;
		#40;
		tck = 1'b0;
		#3;
	endtask : tick
	task idle(input int n);
		logic o;
		repeat (n) tick(1'b0, 1'b0, o);
	endtask : idle
	task ir(input logic [3:0] op);
		logic o;
		tick(1'b0, 1'b0, o);
		tick(1'b1, 1'b0, o);
		tick(1'b1, 1'b0, o);
		tick(1'b0, 1'b0, o);
		tick(1'b0, 1'b0, o);
		for (int i = 0; i < 4; i++) tick(i == 3, op[i], irc[i]);
		tick(1'b1, 1'b0, o);
		tick(1'b0, 1'b0, o);
	endtask : ir
	// Data shift, both directions at once.
	task dr(input int n, input logic [199:0] din);
		logic o;
		dout = '0;
		tick(1'b0, 1'b0, o);
		tick(1'b1, 1'b0, o);
		tick(1'b0, 1'b0, o);
		tick(1'b0, 1'b0, o);
		for (int i = 0; i < n; i++) tick(i == n - 1, din[i], dout[i]);
		tick(1'b1, 1'b0, o);
		tick(1'b0, 1'b0, o);
	endtask : dr
endmodule : dssp_dbg_host
`default_nettype wire

// file: tb/dssp_top_tb.sv
// Testbench of the debug scan select port.
`timescale 1ns/1ps
`default_nettype none
module dssp_top_tb;
	// Identity values are arbitrary.
	localparam logic [31:0] CID = 32'h0a5a_0001;
	localparam logic [31:0] PID = 32'h1f0f_0f0f;
	logic mclk, rst_b, clk_en, scan_mode_select, ice_access_block, ice_mode, tck, tms, tdi;
	logic tdo, tdo_oe, insn_valid, halt_req, core_export_valid, core_tx_valid, core_rx_ack;
	logic debug_chan_rx_event, debug_chan_tx_event;
	logic [31:0] chip_id, insn_word, core_export_word, core_tx_word, dcc_rx_word;
	logic [62:0] func_out, func_oe, pad_in, pad_out, pad_oe;
	int failures = 0;
	int total_checks = 0;
	dssp_top #(.CHIP_ID(CID), .PROC_ID(PID)) DUT (.mclk(mclk), .rst_b(rst_b), .clk_en(clk_en),
		.scan_mode_select(scan_mode_select), .ice_access_block(ice_access_block),
		.ice_mode(ice_mode), .chip_id(chip_id), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
		.tdo_oe(tdo_oe), .func_out(func_out), .func_oe(func_oe), .pad_in(pad_in),
		.pad_out(pad_out), .pad_oe(pad_oe), .insn_valid(insn_valid), .insn_word(insn_word),
		.halt_req(halt_req), .core_export_valid(core_export_valid),
		.core_export_word(core_export_word), .core_tx_valid(core_tx_valid),
		.core_tx_word(core_tx_word), .core_rx_ack(core_rx_ack), .dcc_rx_word(dcc_rx_word),
		.debug_chan_rx_event(debug_chan_rx_event), .debug_chan_tx_event(debug_chan_tx_event));
	dssp_dbg_host host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
	always #2.5 mclk = ~mclk;
	task stop_test;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : stop_test
	task chk(input logic [199:0] g, input logic [199:0] e);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task wt(input int s);
		for (int i = 0; i < 2000; i++) begin
			@(posedge mclk);
			if ((s == 0 && halt_req === 1'b1) || (s == 1 && insn_valid === 1'b1) ||
				(s == 2 && debug_chan_rx_event === 1'b1) || (s == 3 && debug_chan_tx_event === 1'b1))
				return;
		end
		failures++;
		stop_test();
	endtask : wt
	task chip_reset(input logic sel);
		@(posedge mclk);
		scan_mode_select <= sel;
		rst_b <= 1'b0;
		fork
			repeat (16) @(posedge mclk);
			host.idle(6);
		join
		@(posedge mclk) rst_b <= 1'b1;
		host.idle(5);
	endtask : chip_reset
	task t_emul;
		chk(ice_mode, 1'b1);
		chk(chip_id, CID);
		host.dr(32, '0);
		chk(host.dout[31:0], PID);
		@(posedge mclk) func_out <= 63'h1234_5678_9abc_def0;
		repeat (3) @(posedge mclk);
		chk(pad_out, 63'h1234_5678_9abc_def0);
		$display("emulation test done");
	endtask : t_emul
	task t_freeze;
		@(posedge mclk) clk_en <= 1'b0;
		func_out <= 63'h0f;
		func_oe <= 63'h0;
		repeat (4) @(posedge mclk);
		chk(pad_out, 63'h1234_5678_9abc_def0);
		chk(pad_oe, 63'h7fff_ffff_ffff_ffff);
		@(posedge mclk) clk_en <= 1'b1;
		repeat (2) @(posedge mclk);
		chk(pad_out, 63'h0f);
		chk(pad_oe, 63'h0);
		$display("freeze test done");
	endtask : t_freeze
	task t_block;
		@(posedge mclk) ice_access_block <= 1'b1;
		host.ir(4'h8);
		repeat (20) @(posedge mclk);
		chk(halt_req, 1'b0);
		host.ir(4'he);
		host.dr(32, '0);
		chk(host.dout[31:0], 32'h0);
		@(posedge mclk) ice_access_block <= 1'b0;
		$display("block test done");
	endtask : t_block
	task t_debug;
		host.ir(4'h8);
		wt(0);
		chk(halt_req, 1'b1);
		host.ir(4'h2);
		host.dr(4, 1);
		chk(host.dout[3:0], 4'h8);
		host.ir(4'hc);
		@(posedge mclk) core_export_word <= 32'hbeef_0042;
		core_export_valid <= 1'b1;
		@(posedge mclk) core_export_valid <= 1'b0;
		fork
			host.dr(33, {1'b0, 32'he8bd_00ff});
			wt(1);
		join
		chk(host.dout[31:0], 32'hbeef_0042);
		chk(insn_word, 32'he8bd_00ff);
		host.ir(4'h2);
		host.dr(4, 0);
		host.ir(4'hc);
		host.dr(8, '0);
		chk(host.dout[7:0], 8'h01);
		$display("halt test done");
	endtask : t_debug
	task t_chan;
		host.ir(4'h2);
		host.dr(4, 2);
		host.ir(4'hc);
		host.dr(33, {1'b1, 32'h5a5a_c3c3});
		wt(2);
		chk(dcc_rx_word, 32'h5a5a_c3c3);
		@(posedge mclk) core_rx_ack <= 1'b1;
		@(posedge mclk) core_rx_ack <= 1'b0;
		@(posedge mclk) core_tx_word <= 32'h0f1e_2d3c;
		core_tx_valid <= 1'b1;
		@(posedge mclk) core_tx_valid <= 1'b0;
		repeat (2) @(posedge mclk);
		chk(debug_chan_rx_event, 1'b0);
		chk(debug_chan_tx_event, 1'b0);
		host.idle(4);
		host.dr(33, '0);
		chk(host.dout[32:0], {1'b1, 32'h0f1e_2d3c});
		wt(3);
		$display("channel test done");
	endtask : t_chan
	task t_bscan;
		@(posedge mclk) pad_in <= 63'h7fff_ffff_ffff_fffd;
		chip_reset(1'b1);
		chk(ice_mode, 1'b0);
		host.ir(4'h0);
		chk(host.irc, 4'h1);
		host.dr(189, 3);
		repeat (10) @(posedge mclk);
		chk(pad_out[1:0], 2'b01);
		chk(pad_oe[1:0], 2'b01);
		host.dr(190, 1);
		chk(host.dout[5:0], 6'h07);
		chk(host.dout[189], 1'b1);
		host.ir(4'hf);
		host.dr(2, 2'b01);
		chk(host.dout[1:0], 2'b10);
		$display("boundary test done");
	endtask : t_bscan
	initial begin
		mclk = 1'b0;
		rst_b = 1'b0;
		clk_en = 1'b1;
		scan_mode_select = 1'b0;
		ice_access_block = 1'b0;
		func_out = 63'h2;
		func_oe = '1;
		pad_in = '1;
		core_export_valid = 1'b0;
		core_export_word = '0;
		core_tx_valid = 1'b0;
		core_tx_word = '0;
		core_rx_ack = 1'b0;
		chip_reset(1'b0);
		t_emul();
		t_freeze();
		t_block();
		t_debug();
		t_chan();
		func_out <= 63'h2;
		t_bscan();
		stop_test();
	end
endmodule : dssp_top_tb
`default_nettype wire
